// file: hw/dual_comparator_interrupt_ctrl.sv
// control, flags and interrupt logic for two analog comparators
// Behaviour
// - result reads one only while positive input exceeds negative input
// - negative input selects external pin or internal reference
// - each comparator can request an interrupt on output change
// - only comparator one may drive its output onto a port pin
// - change flag in config register set on every output change
// - one shared interrupt; software reads both flags to find source
// - comparators run in idle and power-down, off in total power-down
// - enabled change raises interrupt and wakes in idle or power-down only
// - power control bit switches both comparators off together
//
// The implementer's own choices: strobed register access and the register offsets.
`include "cmp_ctrl_params.svh"
module dual_comparator_interrupt_ctrl
    import cmp_ctrl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  regAddr,
    input  wire logic [7:0]  regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [7:0]  regRdata,
    input  wire logic [1:0]  cmpRaw,
    output logic      [1:0]  cmpPowerOn,
    output logic      [1:0]  refSelect,
    output logic             pinOut,
    output logic             pinOutEn,
    output logic             irq,
    output logic             wakeUp
);
    logic [7:0]  cfg_q [2];
    logic [7:0]  pwrAux_q;
    logic [1:0]  mask_q;
    logic [7:0]  rdata_q;
    logic [1:0]  level;
    logic [1:0]  changed;
    logic [1:0]  settled;
    logic [1:0]  powered;
    logic [1:0]  flags;
    logic        totalPd;
    logic        pinOut_q;
    logic        pinOutEn_q;
    power_mode_t mode;

    assign mode    = power_mode_t'(pwrAux_q[`PWR_MODE_LSB +: 2]);
    assign totalPd = (mode == PM_TOTALPD);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_cmp
            assign powered[gi]   = cfg_q[gi][`CFG_EN_BIT] & ~pwrAux_q[`PWR_CMP_OFF_BIT]
                                   & ~totalPd;
            assign cmpPowerOn[gi] = powered[gi];
            assign refSelect[gi] = cfg_q[gi][`CFG_REFSEL_BIT];
            assign flags[gi]     = cfg_q[gi][`CFG_FLAG_BIT];
            cmp_sync u_sync (
                .sys_clk (sys_clk),
                .resetn  (resetn),
                .rawIn   (cmpRaw[gi]),
                .active  (powered[gi]),
                .level   (level[gi]),
                .changed (changed[gi])
            );
            cmp_settle u_settle (
                .sys_clk (sys_clk),
                .resetn  (resetn),
                .powered (powered[gi]),
                .settled (settled[gi])
            );
            always_ff @(posedge sys_clk)
            begin
                if (!resetn)
                    cfg_q[gi] <= `CFG_RESET;
                else
                begin
                    if (regWrite && regAddr == (gi == 0 ? `ADDR_CMP1_CFG : `ADDR_CMP2_CFG))
                    begin
                        cfg_q[gi][3:0] <= regWdata[3:0];
                        if (regWdata[`CFG_FLAG_BIT] == 1'b0)
                            cfg_q[gi][`CFG_FLAG_BIT] <= 1'b0;
                    end
                    if (regWrite && regAddr == `ADDR_IRQ_STATUS && regWdata[gi])
                        cfg_q[gi][`CFG_FLAG_BIT] <= 1'b0;
                    cfg_q[gi][`CFG_OUT_BIT] <= level[gi];
                    if (changed[gi])
                        cfg_q[gi][`CFG_FLAG_BIT] <= 1'b1;
                    cfg_q[gi][7:6] <= 2'h0;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            pwrAux_q <= 8'h00;
        else if (regWrite && regAddr == `ADDR_PWR_AUX)
            pwrAux_q <= regWdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            mask_q <= 2'h3;
        else if (regWrite && regAddr == `ADDR_IRQ_MASK)
            mask_q <= regWdata[1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            pinOut_q   <= 1'b0;
            pinOutEn_q <= 1'b0;
        end
        else
        begin
            pinOut_q   <= level[0];
            pinOutEn_q <= cfg_q[0][`CFG_OUTEN_BIT];
        end
    end
    assign pinOut   = pinOut_q;
    assign pinOutEn = pinOutEn_q;

    logic [1:0] pend;
    assign pend = flags & {cfg_q[1][`CFG_IEN_BIT], cfg_q[0][`CFG_IEN_BIT]} & mask_q;
    assign irq  = |pend;
    assign wakeUp = irq & ~totalPd & (mode != PM_RUN);

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            rdata_q <= 8'h00;
        else if (regRead)
        begin
            case (regAddr)
                `ADDR_CMP1_CFG:   rdata_q <= cfg_q[0];
                `ADDR_CMP2_CFG:   rdata_q <= cfg_q[1];
                `ADDR_PWR_AUX:    rdata_q <= pwrAux_q;
                `ADDR_IRQ_STATUS: rdata_q <= {4'h0, settled, flags};
                `ADDR_IRQ_MASK:   rdata_q <= {6'h00, mask_q};
                default:          rdata_q <= 8'h00;
            endcase
        end
        else
            rdata_q <= 8'h00;
    end
    assign regRdata = rdata_q;

    AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!resetn)
        changed[0] |=> flags[0])
        else $error("flag 0 not set after change");
    AST_FLAG_SET2: assert property (@(posedge sys_clk) disable iff (!resetn)
        changed[1] |=> flags[1])
        else $error("flag 1 not set after change");
    AST_FLAG_W1C: assert property (@(posedge sys_clk) disable iff (!resetn)
        regWrite && regAddr == `ADDR_IRQ_STATUS && regWdata[0] && !changed[0]
        |=> !flags[0])
        else $error("flag 0 not cleared by status write");
    AST_IRQ_LEVEL: assert property (@(posedge sys_clk) disable iff (!resetn)
        irq |-> (|(flags & mask_q)))
        else $error("irq without unmasked flag");
    AST_TPD_OFF: assert property (@(posedge sys_clk) disable iff (!resetn)
        totalPd |-> cmpPowerOn == 2'h0)
        else $error("comparator powered in total power-down");
    AST_PWR_OFF: assert property (@(posedge sys_clk) disable iff (!resetn)
        pwrAux_q[`PWR_CMP_OFF_BIT] |-> !level[0] && !level[1])
        else $error("level active while powered off");
    AST_PIN_FOLLOW: assert property (@(posedge sys_clk) disable iff (!resetn)
        ##1 pinOut == $past(level[0]))
        else $error("pin not following comparator one");
    AST_NO_WAKE_TPD: assert property (@(posedge sys_clk) disable iff (!resetn)
        totalPd |-> !wakeUp)
        else $error("wake in total power-down");
    AST_OUT_BIT: assert property (@(posedge sys_clk) disable iff (!resetn)
        ##1 cfg_q[1][`CFG_OUT_BIT] == $past(level[1]))
        else $error("output bit not tracking level");
    AST_REF: assert property (@(posedge sys_clk) disable iff (!resetn)
        refSelect[0] == cfg_q[0][`CFG_REFSEL_BIT])
        else $error("reference select mismatch");
    COV_IRQ: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(irq));
    COV_BOTH: cover property (@(posedge sys_clk) disable iff (!resetn) &flags);
    COV_WAKE: cover property (@(posedge sys_clk) disable iff (!resetn) wakeUp);
endmodule : dual_comparator_interrupt_ctrl

// file: hw/cmp_ctrl_params.svh
// constants for the dual comparator control block
`ifndef CMP_CTRL_PARAMS_SVH
`define CMP_CTRL_PARAMS_SVH
`define ADDR_CMP1_CFG     4'h0
`define ADDR_CMP2_CFG     4'h1
`define ADDR_PWR_AUX      4'h2
`define ADDR_IRQ_STATUS   4'h3
`define ADDR_IRQ_MASK     4'h4
`define CFG_EN_BIT        0
`define CFG_REFSEL_BIT    1
`define CFG_OUTEN_BIT     2
`define CFG_IEN_BIT       3
`define CFG_OUT_BIT       4
`define CFG_FLAG_BIT      5
`define PWR_CMP_OFF_BIT   5
`define PWR_MODE_LSB      0
`define CFG_RESET         8'h00
`define SETTLE_NS         10000
`define CLK_PERIOD_NS     5
`define SETTLE_CYCLES     ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_W          11
`endif

// file: hw/cmp_ctrl_pkg.sv
// types for the dual comparator control block
package cmp_ctrl_pkg;
    typedef enum logic [1:0] {
        PM_RUN      = 2'h0,
        PM_IDLE     = 2'h1,
        PM_PWRDOWN  = 2'h3,
        PM_TOTALPD  = 2'h2
    } power_mode_t;
    typedef enum logic [1:0] {
        ST_OFF    = 2'h0,
        ST_SETTLE = 2'h1,
        ST_ACTIVE = 2'h3
    } cmp_state_t;
endpackage : cmp_ctrl_pkg

// file: hw/cmp_sync.sv
// two-stage synchroniser with change detection for one comparator
`include "cmp_ctrl_params.svh"
module cmp_sync
    import cmp_ctrl_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic rawIn,
    input  wire logic active,
    output logic      level,
    output logic      changed
);
    logic stage1_q;
    logic stage2_q;
    logic prev_q;
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end
        else
        begin
            stage1_q <= rawIn;
            stage2_q <= stage1_q;
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            prev_q <= 1'b0;
        else
            prev_q <= stage2_q;
    end
    assign level   = active & stage2_q;
    assign changed = active & (prev_q ^ stage2_q);
endmodule : cmp_sync

// file: hw/cmp_settle.sv
// settling hold-off counter after a comparator is enabled
`include "cmp_ctrl_params.svh"
module cmp_settle
    import cmp_ctrl_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic resetn,
    input  wire logic powered,
    output logic      settled
);
    cmp_state_t               state_q;
    logic [`SETTLE_W-1:0]     count_q;
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state_q <= ST_OFF;
            count_q <= '0;
        end
        else if (!powered)
        begin
            state_q <= ST_OFF;
            count_q <= '0;
        end
        else
        begin
            case (state_q)
                ST_OFF:
                begin
                    state_q <= ST_SETTLE;
                    count_q <= '0;
                end
                ST_SETTLE:
                begin
                    if (count_q == `SETTLE_W'(`SETTLE_CYCLES - 1))
                        state_q <= ST_ACTIVE;
                    else
                        count_q <= count_q + `SETTLE_W'(1);
                end
                ST_ACTIVE:
                    state_q <= ST_ACTIVE;
                default:
                    state_q <= ST_OFF;
            endcase
        end
    end
    assign settled = (state_q == ST_ACTIVE);
endmodule : cmp_settle

// file: tb/cmp_analog_model.sv
// behavioural model of the two analog comparators and the port pin
module cmp_analog_model
(
    input  wire logic             sys_clk,
    input  wire logic [1:0]       cmpPowerOn,
    input  wire logic [1:0]       refSelect,
    input  wire logic             pinOut,
    input  wire logic             pinOutEn,
    input  wire logic [1:0][11:0] posMv,
    input  wire logic [1:0][11:0] negMv,
    input  wire logic [11:0]      refMv,
    output logic      [1:0]       cmpRaw,
    output logic                  pinLevel
);
    timeunit 1ns;
    timeprecision 100ps;
    // one process drives both outputs; an unpowered comparator floats, shown as toggling
    initial
    begin
        cmpRaw   = 2'h0;
        pinLevel = 1'b0;
        forever
        begin
            @(posedge sys_clk);
            for (int i = 0; i < 2; i++)
            begin
                if (cmpPowerOn[i])
                    cmpRaw[i] <= posMv[i] > (refSelect[i] ? refMv : negMv[i]);
                else
                    cmpRaw[i] <= ~cmpRaw[i];
            end
            pinLevel <= pinOutEn ? pinOut : ~pinLevel;
        end
    end
endmodule : cmp_analog_model

// file: tb/dual_comparator_interrupt_ctrl_tb.sv
// self-checking bench for the dual comparator control block
`include "cmp_ctrl_params.svh"
module dual_comparator_interrupt_ctrl_tb
    import cmp_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [3:0] addr; logic [7:0] exp;} row_t;
    logic             sys_clk, resetn, regWrite, regRead, pinOut, pinOutEn, irq, wakeUp;
    logic             pinLevel;
    logic [3:0]       regAddr;
    logic [7:0]       regWdata, regRdata;
    logic [1:0]       cmpRaw, cmpPowerOn, refSelect;
    logic [1:0][11:0] posMv, negMv;
    logic [11:0]      refMv;
    int               n_mismatch, compares, cycles;
    row_t             rows[6];
    logic [7:0]       modes[4] = '{8'h01, 8'h03, 8'h02, 8'h20};
    logic [7:0]       modeExp[4] = '{8'h07, 8'h07, 8'h00, 8'h00};
    dual_comparator_interrupt_ctrl dual_comparator_interrupt_ctrl_inst (.sys_clk(sys_clk),
        .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead), .regRdata(regRdata), .cmpRaw(cmpRaw), .cmpPowerOn(cmpPowerOn),
        .refSelect(refSelect), .pinOut(pinOut), .pinOutEn(pinOutEn), .irq(irq),
        .wakeUp(wakeUp));
    cmp_analog_model cmp_analog_model_inst (.sys_clk(sys_clk), .cmpPowerOn(cmpPowerOn),
        .refSelect(refSelect), .pinOut(pinOut), .pinOutEn(pinOutEn), .posMv(posMv),
        .negMv(negMv), .refMv(refMv), .cmpRaw(cmpRaw), .pinLevel(pinLevel));
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    task automatic report(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : report
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        report(got, exp);
    endtask : chk_reg
    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        report(got, exp);
    endtask : chk_out
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        chk_reg(regRdata, exp);
    endtask : rd
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : wait_cyc
    // bounded wait for the interrupt line
    task automatic wait_irq();
        for (int i = 0; i < 12 && irq !== 1'b1; i++)
            @(posedge sys_clk);
        #1;
    endtask : wait_irq
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            test_done();
        end
    end
    initial
    begin
        {resetn, regWrite, regRead, regAddr, regWdata} = '0;
        posMv = '0;
        negMv = {12'h3E8, 12'h600};
        refMv = 12'h4CE;
        rows = '{'{`ADDR_CMP1_CFG, `CFG_RESET}, '{`ADDR_CMP2_CFG, `CFG_RESET},
            '{`ADDR_PWR_AUX, 8'h00}, '{`ADDR_IRQ_STATUS, 8'h00},
            '{`ADDR_IRQ_MASK, 8'h03}, '{4'hF, 8'h00}};
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        foreach (rows[i])
            rd(rows[i].addr, rows[i].exp);
        $display("test reset values done");
        // enable first, irq off while settling, then clear flag and arm
        wr(`ADDR_CMP1_CFG, 8'h07);
        wait_cyc(`SETTLE_CYCLES);
        wr(`ADDR_CMP1_CFG, 8'h0F);
        wait_cyc(8);
        chk_out({2'b00, cmpPowerOn, refSelect, pinOutEn, irq}, 8'h16);
        @(posedge sys_clk);
        posMv[0] <= 12'h500;
        wait_irq();
        chk_out({6'h00, wakeUp, irq}, 8'h01);
        rd(`ADDR_CMP1_CFG, 8'h3F);
        chk_out({6'h00, pinOut, pinLevel}, 8'h03);
        wr(`ADDR_CMP1_CFG, 8'h0D);
        wait_irq();
        rd(`ADDR_CMP1_CFG, 8'h2D);
        wr(`ADDR_CMP1_CFG, 8'h0D);
        wait_cyc(8);
        rd(`ADDR_CMP1_CFG, 8'h0D);
        chk_out({7'h00, irq}, 8'h00);
        $display("test comparator one done");
        wr(`ADDR_CMP2_CFG, 8'h05);
        wait_cyc(`SETTLE_CYCLES);
        wr(`ADDR_CMP2_CFG, 8'h0D);
        wr(`ADDR_CMP1_CFG, 8'h09);
        wait_cyc(8);
        chk_out({6'h00, refSelect[1], pinOutEn}, 8'h00);
        @(posedge sys_clk);
        posMv[1] <= 12'h7FF;
        wait_irq();
        chk_out({7'h00, irq}, 8'h01);
        rd(`ADDR_IRQ_STATUS, 8'h0E);
        rd(`ADDR_CMP2_CFG, 8'h3D);
        rd(`ADDR_CMP1_CFG, 8'h09);
        wr(`ADDR_IRQ_MASK, 8'h01);
        chk_out({7'h00, irq}, 8'h00);
        wr(`ADDR_IRQ_MASK, 8'h03);
        chk_out({7'h00, irq}, 8'h01);
        $display("test comparator two done");
        foreach (modes[i])
        begin
            wr(`ADDR_PWR_AUX, modes[i]);
            chk_out({5'h00, cmpPowerOn, wakeUp}, modeExp[i]);
        end
        wr(`ADDR_IRQ_STATUS, 8'h02);
        rd(`ADDR_IRQ_STATUS, 8'h00);
        chk_out({7'h00, irq}, 8'h00);
        $display("test power modes done");
        test_done();
    end
endmodule : dual_comparator_interrupt_ctrl_tb
